// ---- design/txll_defs.vh ----
`ifndef TXLL_DEFS_VH
`define TXLL_DEFS_VH
// register byte offsets
`define TXLL_LINK_SEL_ADDR 12'h990
`define TXLL_LINK_DATA_ADDR 12'h994
`define TXLL_LWM_SEL_ADDR 12'h9A0
`define TXLL_LWM_DATA_ADDR 12'h9A4
// select and data register fields
`define TXLL_BUSY_BIT 15
`define TXLL_DIR_BIT 14
`define TXLL_BLOCK_MSB 9
`define TXLL_CHAN_MSB 7
`define TXLL_VALUE_MSB 9
// reset values
`define TXLL_SEL_RESET 16'h0000
`define TXLL_DATA_RESET 10'h000
// cycles a ram access spends in the run state; busy also covers the done cycle
`define TXLL_ACCESS_CYCLES 4'h2
// axi responses
`define TXLL_RESP_OKAY 2'b00
`define TXLL_RESP_SLVERR 2'b10
`endif

// ---- design/txll_ram.v ----
`timescale 1ns/1ps
`default_nettype none
// flip-flop table with one indexed port; read data is registered
module txll_ram #(
  parameter AW = 10,
  parameter DW = 10
) (
  input wire sys_clk,
  input wire clkEn,
  input wire wrEn,
  input wire rdEn,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wrData,
  output reg [DW-1:0] rdData
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the table itself: contents are defined by software writes
  always @(posedge sys_clk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[addr] <= wrData;
      end
      if (rdEn) begin
        rdData <= mem[addr];
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/txll_top.v ----
// What this block does
// - a 10-bit block index in the link select register picks blocks 0..1023.
// - writing direction 1 to link select fetches that link, busy until ready.
// - writing direction 0 to link select stores link data, busy until done.
// - each select register has a read-only busy bit, 1 only during access.
// - link data bits 9..0 hold the next block number, 000h..3FFh.
// - an 8-bit channel index picks channel 1 (00h) up to 256 (FFh).
// - writing direction 1 to watermark select fetches that entry, busy.
// - writing direction 0 to watermark select stores data, busy until done.
// - each channel keeps a 10-bit low watermark, blocks left before refill.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "txll_defs.vh"
module txll_top #(
  parameter BLOCK_AW = 10,
  parameter CHAN_AW = 8,
  parameter VAL_W = 10
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clkEn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [CHAN_AW-1:0] dmaChanIndex,
  output reg [VAL_W-1:0] dmaLowWatermark
);
  // access sequencer states
  // idle waits for a direction write, run counts the ram slot down,
  // done hands the result over and drops busy on the same edge
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_DONE = 2'b10;

  // write channel holding registers
  reg [11:0] awAddr_r;
  reg awHeld_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg wHeld_r;
  // link table select and data
  reg [BLOCK_AW-1:0] blockIndex_r;
  reg linkDir_r;
  reg linkBusy_r;
  reg [VAL_W-1:0] linkData_r;
  // watermark table select and data
  reg [CHAN_AW-1:0] chanIndex_r;
  reg lwmDir_r;
  reg lwmBusy_r;
  reg [VAL_W-1:0] lwmData_r;
  // sequencer states and slot counters
  reg [1:0] linkState_r;
  reg [1:0] lwmState_r;
  reg [3:0] linkCnt_r;
  reg [3:0] lwmCnt_r;
  reg dmaPhase_r;
  // registered table outputs
  wire [VAL_W-1:0] linkRdData;
  wire [VAL_W-1:0] lwmRdData;

  // a write acts once address and data are both held and the last
  // response is gone, so a slow bready cannot lose a register write
  wire wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire lowByte = wStrb_r[0];
  wire highByte = wStrb_r[1];
  wire hitLinkSel = wrFire && (awAddr_r == `TXLL_LINK_SEL_ADDR);
  wire hitLinkData = wrFire && (awAddr_r == `TXLL_LINK_DATA_ADDR);
  wire hitLwmSel = wrFire && (awAddr_r == `TXLL_LWM_SEL_ADDR);
  wire hitLwmData = wrFire && (awAddr_r == `TXLL_LWM_DATA_ADDR);
  // an access starts only when the high byte (direction) is written
  wire linkStart = hitLinkSel && highByte && !linkBusy_r;
  wire lwmStart = hitLwmSel && highByte && !lwmBusy_r;

  // ram strobes: reads pulse once, writes on the last run cycle
  // the counter keeps busy up for a fixed span whatever the table
  // timing, so a poll never sees a clear before the result lands
  wire linkRamRd = (linkState_r == ST_RUN) && linkDir_r &&
    (linkCnt_r == 4'h1);
  wire linkRamWr = (linkState_r == ST_RUN) && !linkDir_r &&
    (linkCnt_r == 4'h1);
  wire lwmRamRd = (lwmState_r == ST_RUN) && lwmDir_r &&
    (lwmCnt_r == 4'h1);
  wire lwmRamWr = (lwmState_r == ST_RUN) && !lwmDir_r &&
    (lwmCnt_r == 4'h1);
  // dma lookup borrows the port only while software leaves it idle
  // software always wins the port; the lookup just waits, so the
  // watermark seen by the dma side can lag by a few cycles
  wire dmaRd = dmaPhase_r && (lwmState_r == ST_IDLE) && !lwmStart;
  wire [CHAN_AW-1:0] lwmAddr = dmaRd ? dmaChanIndex : chanIndex_r;

  txll_ram #(
    .AW(BLOCK_AW),
    .DW(VAL_W)
  ) linkRam (
    .sys_clk(sys_clk),
    .clkEn(clkEn),
    .wrEn(linkRamWr),
    .rdEn(linkRamRd),
    .addr(blockIndex_r),
    .wrData(linkData_r),
    .rdData(linkRdData)
  );

  txll_ram #(
    .AW(CHAN_AW),
    .DW(VAL_W)
  ) lwmRam (
    .sys_clk(sys_clk),
    .clkEn(clkEn),
    .wrEn(lwmRamWr),
    .rdEn(lwmRamRd || dmaRd),
    .addr(lwmAddr),
    .wrData(lwmData_r),
    .rdData(lwmRdData)
  );

  // write address and data are caught independently, in either order
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      awAddr_r <= 12'h000;
      awHeld_r <= 1'b0;
      s_axi_awready <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      wHeld_r <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TXLL_RESP_OKAY;
    end else if (clkEn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      // each ready pulses once per captured beat; a master that still
      // holds valid after the pulse is not captured twice
      if (s_axi_awvalid && !awHeld_r && !s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !wHeld_r && !s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped writes still get a response so the master never hangs
        if (hitLinkSel || hitLinkData || hitLwmSel || hitLwmData) begin
          s_axi_bresp <= `TXLL_RESP_OKAY;
        end else begin
          s_axi_bresp <= `TXLL_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // link pointer select, data and sequencer
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      blockIndex_r <= {BLOCK_AW{1'b0}};
      linkDir_r <= 1'b0;
      linkBusy_r <= 1'b0;
      linkData_r <= `TXLL_DATA_RESET;
      linkState_r <= ST_IDLE;
      linkCnt_r <= 4'h0;
    end else if (clkEn) begin
      // index is frozen while busy so the access cannot be retargeted
      if (hitLinkSel && !linkBusy_r) begin
        if (lowByte) begin
          blockIndex_r[7:0] <= wData_r[7:0];
        end
        if (highByte) begin
          blockIndex_r[BLOCK_AW-1:8] <= wData_r[`TXLL_BLOCK_MSB:8];
          linkDir_r <= wData_r[`TXLL_DIR_BIT];
        end
      end
      if (hitLinkData && !linkBusy_r) begin
        if (lowByte) begin
          linkData_r[7:0] <= wData_r[7:0];
        end
        if (highByte) begin
          linkData_r[VAL_W-1:8] <= wData_r[`TXLL_VALUE_MSB:8];
        end
      end
      // the table is written on the last run cycle, so the index and
      // data frozen at start are the ones that land
      case (linkState_r)
        ST_IDLE: begin
          if (linkStart) begin
            linkBusy_r <= 1'b1;
            linkCnt_r <= `TXLL_ACCESS_CYCLES;
            linkState_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          linkCnt_r <= linkCnt_r - 4'h1;
          if (linkCnt_r == 4'h1) begin
            linkState_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (linkDir_r) begin
            linkData_r <= linkRdData;
          end
          linkBusy_r <= 1'b0;
          linkState_r <= ST_IDLE;
        end
        default: begin
          linkState_r <= ST_IDLE;
        end
      endcase
    end
  end

  // low watermark select, data and sequencer
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chanIndex_r <= {CHAN_AW{1'b0}};
      lwmDir_r <= 1'b0;
      lwmBusy_r <= 1'b0;
      lwmData_r <= `TXLL_DATA_RESET;
      lwmState_r <= ST_IDLE;
      lwmCnt_r <= 4'h0;
    end else if (clkEn) begin
      if (hitLwmSel && !lwmBusy_r) begin
        if (lowByte) begin
          chanIndex_r <= wData_r[`TXLL_CHAN_MSB:0];
        end
        if (highByte) begin
          lwmDir_r <= wData_r[`TXLL_DIR_BIT];
        end
      end
      if (hitLwmData && !lwmBusy_r) begin
        if (lowByte) begin
          lwmData_r[7:0] <= wData_r[7:0];
        end
        if (highByte) begin
          lwmData_r[VAL_W-1:8] <= wData_r[`TXLL_VALUE_MSB:8];
        end
      end
      // same timing as the link sequencer; the dma lookup stays off
      // the port from start until done
      case (lwmState_r)
        ST_IDLE: begin
          if (lwmStart) begin
            lwmBusy_r <= 1'b1;
            lwmCnt_r <= `TXLL_ACCESS_CYCLES;
            lwmState_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          lwmCnt_r <= lwmCnt_r - 4'h1;
          if (lwmCnt_r == 4'h1) begin
            lwmState_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (lwmDir_r) begin
            lwmData_r <= lwmRdData;
          end
          lwmBusy_r <= 1'b0;
          lwmState_r <= ST_IDLE;
        end
        default: begin
          lwmState_r <= ST_IDLE;
        end
      endcase
    end
  end

  // dma side watermark lookup; one cycle to read, one to capture
  // the result is meaningless until the first lookup after reset
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dmaPhase_r <= 1'b0;
      dmaLowWatermark <= `TXLL_DATA_RESET;
    end else if (clkEn) begin
      if (dmaPhase_r) begin
        dmaPhase_r <= ~dmaRd;
      end else begin
        dmaLowWatermark <= lwmRdData;
        dmaPhase_r <= 1'b1;
      end
    end
  end

  // read channel: one outstanding read, answered in the same cycle as arready
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TXLL_RESP_OKAY;
    end else if (clkEn) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TXLL_RESP_OKAY;
        // busy and direction read back live; a poll sees busy fall on
        // the edge that the fetched value lands in the data register
        if (s_axi_araddr == `TXLL_LINK_SEL_ADDR) begin
          s_axi_rdata <= {16'h0000, linkBusy_r, linkDir_r, 4'h0,
            blockIndex_r};
        end else if (s_axi_araddr == `TXLL_LINK_DATA_ADDR) begin
          s_axi_rdata <= {22'h000000, linkData_r};
        end else if (s_axi_araddr == `TXLL_LWM_SEL_ADDR) begin
          s_axi_rdata <= {16'h0000, lwmBusy_r, lwmDir_r, 6'h00,
            chanIndex_r};
        end else if (s_axi_araddr == `TXLL_LWM_DATA_ADDR) begin
          s_axi_rdata <= {22'h000000, lwmData_r};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `TXLL_RESP_SLVERR;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/txll_checker_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "txll_defs.vh"
module txll_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // read answers are judged at the edge that takes the address
  wire rdTake = s_axi_arvalid && s_axi_arready;
  function automatic logic known(input logic [11:0] a);
    known = a inside {`TXLL_LINK_SEL_ADDR, `TXLL_LINK_DATA_ADDR,
      `TXLL_LWM_SEL_ADDR, `TXLL_LWM_DATA_ADDR};
  endfunction
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  a_awready_pulse: assert property (s_axi_awready |=>
    !s_axi_awready) else $error("awready too long");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |->
    ##[1:8] s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |->
    ##[1:4] (s_axi_arready && s_axi_rvalid)) else $error("no read answer");
  a_unmapped_err: assert property (rdTake && !known(s_axi_araddr) |->
    s_axi_rresp == `TXLL_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_link_sel_zero: assert property (rdTake &&
    s_axi_araddr == `TXLL_LINK_SEL_ADDR |-> s_axi_rdata[31:16] == 16'h0
    && s_axi_rdata[13:10] == 4'h0) else $error("link select spare bits");
  a_lwm_sel_zero: assert property (rdTake &&
    s_axi_araddr == `TXLL_LWM_SEL_ADDR |-> s_axi_rdata[31:16] == 16'h0
    && s_axi_rdata[13:8] == 6'h0) else $error("watermark select spare bits");
  a_data_width: assert property (rdTake &&
    (s_axi_araddr == `TXLL_LINK_DATA_ADDR || s_axi_araddr ==
    `TXLL_LWM_DATA_ADDR) |-> s_axi_rdata[31:10] == 22'h0)
    else $error("data register spare bits");
endmodule
bind txll_top txll_checker txll_checker_inst (.sys_clk(sys_clk),
  .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp));
`default_nettype wire

// ---- sim/txll_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "txll_defs.vh"
module txll_top_tb;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [11:0] awAddr = 12'h0;
  logic [11:0] arAddr = 12'h0;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'h0;
  logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
  logic arValid = 1'h0, rReady = 1'h0;
  logic [7:0] dmaIdx = 8'h0;
  logic clkEn = 1'h1;
  logic slowResp = 1'h0;
  logic [9:0] lastLink;
  wire awReady, wReady, bValid, arReady, rValid;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  wire [9:0] dmaWm;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [15:0] lf = 16'h0050;
  logic [31:0] rq;
  logic [9:0] ix [4];
  logic [9:0] vv [4];
  logic [33:0] expQ [$];
  logic [33:0] mskQ [$];
  string nmQ [$];
  // clock enable is dropped once to see that the dma watermark lookup result freezes
  txll_top txll_top_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .clkEn(clkEn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .dmaChanIndex(dmaIdx), .dmaLowWatermark(dmaWm));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input string nm, input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // a mask of zero keeps only the response code under test
  task note(input string nm, input logic [1:0] r, input logic [31:0] d,
    input logic [31:0] m);
    nmQ.push_back(nm);
    expQ.push_back({r, d & m});
    mskQ.push_back({2'h3, m});
  endtask
  // oldest note meets each response as it is handed over
  always @(posedge sys_clk) begin
    if ((bValid && bReady) || (rValid && rReady))
      check(nmQ.pop_front(), (bValid && bReady ? {bResp, 32'h0} :
        {rResp, rData}) & mskQ.pop_front(), expQ.pop_front());
  end
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    note("write response", r, 32'h0, 32'h0);
    @(posedge sys_clk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= !slowResp;
    fork
      begin
        do @(posedge sys_clk); while (!awReady);
        awValid <= 1'h0;
      end
      begin
        do @(posedge sys_clk); while (!wReady);
        wValid <= 1'h0;
      end
    join
    // a slow master leaves the response waiting for two cycles
    if (slowResp) begin
      repeat (2) @(posedge sys_clk);
      bReady <= 1'h1;
    end
    do @(posedge sys_clk); while (!bValid);
    bReady <= 1'h0;
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [1:0] r,
    input logic [31:0] d, input logic [31:0] m);
    note(nm, r, d, m);
    @(posedge sys_clk);
    arAddr <= a;
    arValid <= 1'h1;
    rReady <= !slowResp;
    do @(posedge sys_clk); while (!arReady);
    arValid <= 1'h0;
    if (slowResp) begin
      repeat (2) @(posedge sys_clk);
      rReady <= 1'h1;
      do @(posedge sys_clk); while (!rValid);
    end else begin
      while (!rValid) @(posedge sys_clk);
    end
    rq = rData;
    rReady <= 1'h0;
  endtask
  // bounded wait for the busy flag to fall
  task poll(input logic [11:0] sel);
    rq = 32'hFFFF;
    for (int i = 0; i < 20 && rq[15] !== 1'h0; i++)
      rd("poll", sel, `TXLL_RESP_OKAY, 32'h0, 32'h0);
    check("busy clear", {33'h0, rq[15]}, 34'h0);
  endtask
  task store(input logic [11:0] sel, input logic [9:0] idx,
    input logic [9:0] v);
    wr(sel + 12'h4, {22'h0, v}, 4'h3, `TXLL_RESP_OKAY);
    wr(sel, {22'h0, idx}, 4'h3, `TXLL_RESP_OKAY);
    rd("busy set", sel, `TXLL_RESP_OKAY, {22'h20, idx}, 32'hFFFFFFFF);
    poll(sel);
  endtask
  task fetch(input logic [11:0] sel, input logic [9:0] idx,
    input logic [9:0] v);
    wr(sel, {16'h0, 6'h10, idx}, 4'h3, `TXLL_RESP_OKAY);
    poll(sel);
    rd("fetched", sel + 12'h4, `TXLL_RESP_OKAY, {22'h0, v}, 32'hFFFFFFFF);
  endtask
  // walk the one table picked by sel: store four entries, then fetch them back
  task table_pass(input logic [11:0] sel, input logic [9:0] top);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      ix[i] = i == 0 ? 10'h0 : i == 1 ? top :
        i == 2 ? top >> 1 : lf[9:0] & top;
      vv[i] = sel == `TXLL_LINK_SEL_ADDR ? ix[i] ^ 10'h2A5 : lf[8:0] | 10'h1;
      store(sel, ix[i], vv[i]);
    end
    for (int i = 0; i < 4; i++)
      fetch(sel, ix[i], vv[i]);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'h1;
    // the map test lets every response wait before taking it
    slowResp = 1'h1;
    rd("link sel", `TXLL_LINK_SEL_ADDR, 2'h0, 32'h0, 32'hFFFFFFFF);
    rd("wm sel", `TXLL_LWM_SEL_ADDR, 2'h0, 32'h0, 32'hFFFFFFFF);
    rd("unmapped", 12'h998, `TXLL_RESP_SLVERR, 32'h0, 32'hFFFFFFFF);
    wr(12'h9A8, 32'h1234, 4'hF, `TXLL_RESP_SLVERR);
    slowResp = 1'h0;
    $display("reset and map test done");
    table_pass(`TXLL_LINK_SEL_ADDR, 10'h3FF);
    lastLink = ix[3];
    $display("link table test done");
    table_pass(`TXLL_LWM_SEL_ADDR, 10'h0FF);
    $display("watermark table test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      dmaIdx <= ix[i][7:0];
      repeat (8) @(posedge sys_clk);
      check("dma watermark", {24'h0, dmaWm}, {24'h0, vv[i]});
    end
    $display("dma watermark test done");
    // clock enable low must hold the lookup result still
    @(posedge sys_clk);
    clkEn <= 1'h0;
    dmaIdx <= ix[0][7:0];
    repeat (8) @(posedge sys_clk);
    check("frozen watermark", {24'h0, dmaWm}, {24'h0, vv[3]});
    clkEn <= 1'h1;
    repeat (8) @(posedge sys_clk);
    check("thawed watermark", {24'h0, dmaWm}, {24'h0, vv[0]});
    $display("clock enable test done");
    // no direction byte strobed, so no access may start; the upper
    // index bits and the direction stay from the last link fetch
    wr(`TXLL_LINK_SEL_ADDR, 32'h4005, 4'h1, `TXLL_RESP_OKAY);
    rd("no start", `TXLL_LINK_SEL_ADDR, 2'h0,
      {22'h10, lastLink[9:8], 8'h05}, 32'hFFFFFFFF);
    $display("strobe test done");
    give_verdict;
  end
  // about 350 cycles are needed; cut off well beyond that
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict;
  end
endmodule
`default_nettype wire
